// *** pkg/uei_pkg.sv ***
package uei_pkg;
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 16;
  localparam int         EP_W         = 4;
  localparam int         OVR_W        = 2;
  // register offsets
  localparam logic [7:0] TX_PEND_OFS  = 8'h02;
  localparam logic [7:0] RX_PEND_OFS  = 8'h04;
  localparam logic [7:0] TX_MASK_OFS  = 8'h06;
  localparam logic [7:0] RX_MASK_OFS  = 8'h08;
  localparam logic [7:0] OVR_STAT_OFS = 8'h0C;
  localparam logic [7:0] OVR_CLR_OFS  = 8'h0E;
  localparam logic [7:0] OVR_EN_OFS   = 8'h10;
  // reset values and implemented bits
  localparam logic [3:0] PEND_RST     = 4'h0;
  localparam logic [3:0] TX_MASK_RST  = 4'hF;
  localparam logic [3:0] RX_MASK_RST  = 4'hE;
  localparam logic [1:0] OVR_RST      = 2'h0;
  localparam logic [3:0] TX_IMPL      = 4'hF;
  localparam logic [3:0] RX_IMPL      = 4'hE;
  // overrun field positions
  localparam int         OVR_TX_BIT   = 0;
  localparam int         OVR_RX_BIT   = 1;
  // read data latency in cycles
  localparam int         RD_LAT       = 1;
endpackage

// *** logic/uei_pend_bank.sv ***
module uei_pend_bank (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // endpoint side
  input  wire logic [uei_pkg::EP_W-1:0] impl_mask,
  input  wire logic [uei_pkg::EP_W-1:0] ep_cfg,
  input  wire logic [uei_pkg::EP_W-1:0] ep_event,
  // register side
  input  wire logic                     rd_clr,
  output logic      [uei_pkg::EP_W-1:0] pend,
  output logic      [uei_pkg::EP_W-1:0] ovr
);
  import uei_pkg::*;
  logic [EP_W-1:0] pend_ff;
  logic [EP_W-1:0] nxt_pend;
  wire  [EP_W-1:0] live = impl_mask & ep_cfg;
  wire  [EP_W-1:0] hit  = ep_event & live;
  // event sets over the clearing read; unconfigured bits drop
  assign nxt_pend = ((pend_ff & ~{EP_W{rd_clr}}) | hit) & live;
  assign ovr      = hit & pend_ff & ~{EP_W{rd_clr}};
  assign pend     = pend_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_ff <= PEND_RST;
    end else begin
      pend_ff <= nxt_pend;
    end
  end
  set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_clr |=> ((pend_ff & $past(hit)) == $past(hit)))
    else $error("event lost at clearing read");
endmodule

// *** logic/uei_evt_irq.sv ***
module uei_evt_irq (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // events
  input  wire logic [uei_pkg::OVR_W-1:0] ev,
  // software access
  input  wire logic                      clr_wr,
  input  wire logic                      en_wr,
  input  wire logic [uei_pkg::OVR_W-1:0] wr_bits,
  output logic      [uei_pkg::OVR_W-1:0] stat,
  output logic      [uei_pkg::OVR_W-1:0] en,
  output logic                           irq
);
  import uei_pkg::*;
  logic [OVR_W-1:0] stat_ff;
  logic [OVR_W-1:0] en_ff;
  logic             irq_ff;
  wire  [OVR_W-1:0] clr_bits = clr_wr ? wr_bits : OVR_RST;
  wire  [OVR_W-1:0] nxt_stat = (stat_ff & ~clr_bits) | ev;
  wire  [OVR_W-1:0] nxt_en   = en_wr ? wr_bits : en_ff;
  wire              nxt_irq  = |(stat_ff & en_ff);
  assign stat = stat_ff;
  assign en   = en_ff;
  assign irq  = irq_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= OVR_RST;
      en_ff   <= OVR_RST;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      en_ff   <= nxt_en;
      irq_ff  <= nxt_irq;
    end
  end
endmodule

// *** logic/uei_usb_ep_irq.sv ***
// Overview of operation
// - receive pending register at 0x004, 16 bits, read only, resets to zero.
// - receive pending bits 3..1 read one while that endpoint's receive event is pending.
// - bits 2 and 1 act like bit 3; bit 0 and 15..4 read zero.
// - pending bits of unconfigured endpoints always read zero.
// - reading receive pending returns flags and clears all flags active then, except those with a new event in that cycle.
// - transmit mask register at 0x006, 16 bits, bits 3..0 read-write.
// - set transmit mask bit with pending flag raises the interrupt request.
// - cleared mask bit still lets flag set but keeps it off the request.
// - transmit mask bit 0 gates the combined control endpoint flag.
// - transmit mask resets to 0x000F; bits 15..4 read zero.
// - receive mask register at 0x008; bits 3..1 gate receive pending flags.
// - receive mask resets to 0x000E; bit 0 and 15..4 read zero.
// - transmit pending at 0x002, clear on read; bit 0 is control endpoint.
module uei_usb_ep_irq (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // register port
  input  wire logic [uei_pkg::ADDR_W-1:0]   addr,
  input  wire logic [uei_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [uei_pkg::DATA_W-1:0]   rd_data,
  // endpoint events and configuration
  input  wire logic [uei_pkg::EP_W-1:0]     tx_ep_event,
  input  wire logic [uei_pkg::EP_W-1:0]     rx_ep_event,
  input  wire logic [uei_pkg::EP_W-1:0]     tx_ep_cfg,
  input  wire logic [uei_pkg::EP_W-1:0]     rx_ep_cfg,
  // interrupt requests
  output logic                              usb_irq,
  output logic                              ovr_irq
);
  import uei_pkg::*;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
    is_reg = (a == ofs);
  endfunction

  function automatic logic irq_any(input logic [EP_W-1:0] p,
                                   input logic [EP_W-1:0] m);
    irq_any = |(p & m);
  endfunction

  function automatic logic [DATA_W-1:0] pad16(input logic [EP_W-1:0] v);
    pad16 = {12'h000, v};
  endfunction

  logic [EP_W-1:0]   tx_pend;
  logic [EP_W-1:0]   rx_pend;
  logic [EP_W-1:0]   tx_ovr;
  logic [EP_W-1:0]   rx_ovr;
  logic [EP_W-1:0]   tx_mask_ff;
  logic [EP_W-1:0]   rx_mask_ff;
  logic [EP_W-1:0]   nxt_tx_mask;
  logic [EP_W-1:0]   nxt_rx_mask;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic              usb_irq_ff;
  logic              nxt_usb_irq;
  logic [OVR_W-1:0]  ovr_stat;
  logic [OVR_W-1:0]  ovr_en;
  logic [OVR_W-1:0]  ovr_ev;
  logic [DATA_W-1:0] rd_mux;

  // address decode
  wire sel_tx_pend  = is_reg(addr, TX_PEND_OFS);
  wire sel_rx_pend  = is_reg(addr, RX_PEND_OFS);
  wire sel_tx_mask  = is_reg(addr, TX_MASK_OFS);
  wire sel_rx_mask  = is_reg(addr, RX_MASK_OFS);
  wire sel_ovr_stat = is_reg(addr, OVR_STAT_OFS);
  wire sel_ovr_clr  = is_reg(addr, OVR_CLR_OFS);
  wire sel_ovr_en   = is_reg(addr, OVR_EN_OFS);

  // strobes
  wire rd_tx_pend  = rd_en & sel_tx_pend;
  wire rd_rx_pend  = rd_en & sel_rx_pend;
  wire wr_tx_mask  = wr_en & sel_tx_mask;
  wire wr_rx_mask  = wr_en & sel_rx_mask;
  wire wr_ovr_clr  = wr_en & sel_ovr_clr;
  wire wr_ovr_en   = wr_en & sel_ovr_en;

  // transmit pending flags, bit 0 is the control endpoint
  uei_pend_bank u_tx_bank (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .impl_mask (TX_IMPL),
    .ep_cfg    (tx_ep_cfg),
    .ep_event  (tx_ep_event),
    .rd_clr    (rd_tx_pend),
    .pend      (tx_pend),
    .ovr       (tx_ovr)
  );

  // receive pending flags, bit 0 reserved
  uei_pend_bank u_rx_bank (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .impl_mask (RX_IMPL),
    .ep_cfg    (rx_ep_cfg),
    .ep_event  (rx_ep_event),
    .rd_clr    (rd_rx_pend),
    .pend      (rx_pend),
    .ovr       (rx_ovr)
  );

  // overrun events: a second event on a flag still pending
  assign ovr_ev[OVR_TX_BIT] = |tx_ovr;
  assign ovr_ev[OVR_RX_BIT] = |rx_ovr;

  uei_evt_irq u_ovr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ev      (ovr_ev),
    .clr_wr  (wr_ovr_clr),
    .en_wr   (wr_ovr_en),
    .wr_bits (wr_data[OVR_W-1:0]),
    .stat    (ovr_stat),
    .en      (ovr_en),
    .irq     (ovr_irq)
  );

  // mask registers, reserved bits held at zero
  assign nxt_tx_mask = wr_tx_mask ? (wr_data[EP_W-1:0] & TX_IMPL) : tx_mask_ff;
  assign nxt_rx_mask = wr_rx_mask ? (wr_data[EP_W-1:0] & RX_IMPL) : rx_mask_ff;

  // read data select, unmapped and write-only read zero
  assign rd_mux = sel_tx_pend  ? pad16(tx_pend) :
                  sel_rx_pend  ? pad16(rx_pend) :
                  sel_tx_mask  ? pad16(tx_mask_ff) :
                  sel_rx_mask  ? pad16(rx_mask_ff) :
                  sel_ovr_stat ? {14'h0, ovr_stat} :
                  sel_ovr_en   ? {14'h0, ovr_en} :
                  16'h0000;
  assign nxt_rd_data = rd_en ? rd_mux : 16'h0000;

  // combined request, masks gate pending flags
  assign nxt_usb_irq = irq_any(tx_pend, tx_mask_ff) | irq_any(rx_pend, rx_mask_ff);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_mask_ff <= TX_MASK_RST;
      rx_mask_ff <= RX_MASK_RST;
    end else begin
      tx_mask_ff <= nxt_tx_mask;
      rx_mask_ff <= nxt_rx_mask;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 16'h0000;
      usb_irq_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      usb_irq_ff <= nxt_usb_irq;
    end
  end

  assign rd_data = rd_data_ff;
  assign usb_irq = usb_irq_ff;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  rx_rd_data_a: assert property (
    rd_rx_pend |=> rd_data_ff == pad16($past(rx_pend)))
    else $error("receive pending read data wrong");

  rx_set_a: assert property (
    (rx_ep_event & rx_ep_cfg & RX_IMPL) != 4'h0
    |=> (rx_pend & $past(rx_ep_event & rx_ep_cfg & RX_IMPL))
        == $past(rx_ep_event & rx_ep_cfg & RX_IMPL))
    else $error("receive event did not set pending");

  rx_reserved_a: assert property (
    $past(rd_rx_pend) |-> (rd_data_ff[15:4] == 12'h000) && !rd_data_ff[0])
    else $error("receive reserved bits not zero");

  rx_bit0_a: assert property (
    !rx_pend[0] && !rx_mask_ff[0])
    else $error("receive bit 0 set");

  unconf_zero_a: assert property (
    ((tx_pend & ~$past(tx_ep_cfg)) == 4'h0) && ((rx_pend & ~$past(rx_ep_cfg)) == 4'h0))
    else $error("unconfigured endpoint pending");

  rx_clear_a: assert property (
    rd_rx_pend |=> (rx_pend & ~$past(rx_ep_event)) == 4'h0)
    else $error("read did not clear receive flags");

  tx_clear_a: assert property (
    rd_tx_pend |=> ((tx_pend & ~$past(tx_ep_event)) == 4'h0)
                   && (rd_data_ff == pad16($past(tx_pend))))
    else $error("transmit pending read wrong");

  mask_wr_a: assert property (
    wr_tx_mask |=> tx_mask_ff == $past(wr_data[3:0]))
    else $error("transmit mask write lost");

  rx_mask_wr_a: assert property (
    wr_rx_mask |=> rx_mask_ff == ($past(wr_data[3:0]) & RX_IMPL))
    else $error("receive mask write wrong");

  irq_on_a: assert property (
    (irq_any(tx_pend, tx_mask_ff) || irq_any(rx_pend, rx_mask_ff)) |=> usb_irq)
    else $error("request missing");

  irq_off_a: assert property (
    !(irq_any(tx_pend, tx_mask_ff) || irq_any(rx_pend, rx_mask_ff)) |=> !usb_irq)
    else $error("request without enabled flag");

  ep0_gate_a: assert property (
    (tx_pend == 4'h1) && (rx_pend == 4'h0) && !tx_mask_ff[0] |=> !usb_irq)
    else $error("control endpoint not gated");

  mask_rst_a: assert property (
    $fell(rst) |-> (tx_mask_ff == TX_MASK_RST) && (rx_mask_ff == RX_MASK_RST))
    else $error("mask reset value wrong");

  rx_keep_a: assert property (
    rd_rx_pend && ((rx_ep_event & rx_ep_cfg & RX_IMPL) != 4'h0)
    |=> (rx_pend & $past(rx_ep_event & rx_ep_cfg & RX_IMPL))
        == $past(rx_ep_event & rx_ep_cfg & RX_IMPL))
    else $error("event lost at read");

  irq_lag_a: assert property (
    $rose(usb_irq) |-> $past(nxt_usb_irq))
    else $error("request rose without cause");

  read_clash_c: cover property (rd_rx_pend && (rx_ep_event & rx_ep_cfg & RX_IMPL) != 4'h0);
  irq_rise_c: cover property ($rose(usb_irq));
  masked_c: cover property ((tx_pend != 4'h0) && ((tx_pend & tx_mask_ff) == 4'h0));
  ovr_irq_c: cover property ($rose(ovr_irq));
endmodule

// *** tb/uei_ep_src.sv ***
module uei_ep_src (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // requests from the bench
  input  wire logic [uei_pkg::EP_W-1:0] fire_tx,
  input  wire logic [uei_pkg::EP_W-1:0] fire_rx,
  // endpoint events toward the block
  output logic      [uei_pkg::EP_W-1:0] tx_ep_event,
  output logic      [uei_pkg::EP_W-1:0] rx_ep_event
);
  timeunit 1ns;
  timeprecision 1ns;
  import uei_pkg::*;

  // one registered event pulse per request, as an endpoint data path would raise it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_ep_event <= 4'h0;
      rx_ep_event <= 4'h0;
    end else begin
      tx_ep_event <= fire_tx;
      rx_ep_event <= fire_rx;
    end
  end
endmodule

// *** tb/usb_endpoint_irq_status_enable_tb.sv ***
module usb_endpoint_irq_status_enable_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uei_pkg::*;

  typedef struct {logic wr; logic [7:0] a; logic [15:0] d;} uei_row_t;

  logic              ref_clk;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [EP_W-1:0]   tx_ep_event;
  logic [EP_W-1:0]   rx_ep_event;
  logic [EP_W-1:0]   tx_ep_cfg;
  logic [EP_W-1:0]   rx_ep_cfg;
  logic [EP_W-1:0]   fire_tx;
  logic [EP_W-1:0]   fire_rx;
  logic              usb_irq;
  logic              ovr_irq;
  logic [DATA_W-1:0] v;
  int                fails;
  int                cmp_count;
  uei_row_t          rows [12] = '{
    '{1'b0, 8'h02, 16'h0000}, '{1'b0, 8'h04, 16'h0000}, '{1'b0, 8'h06, 16'h000F},
    '{1'b0, 8'h08, 16'h000E}, '{1'b0, 8'h0A, 16'h0000}, '{1'b1, 8'h06, 16'hFFF0},
    '{1'b0, 8'h06, 16'h0000}, '{1'b1, 8'h08, 16'hFFFF}, '{1'b0, 8'h08, 16'h000E},
    '{1'b1, 8'h04, 16'hFFFF}, '{1'b0, 8'h04, 16'h0000}, '{1'b1, 8'h06, 16'hFFFF}};

  uei_ep_src src (.ref_clk(ref_clk), .rst(rst), .fire_tx(fire_tx), .fire_rx(fire_rx),
                  .tx_ep_event(tx_ep_event), .rx_ep_event(rx_ep_event));

  uei_usb_ep_irq dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                      .rd_en(rd_en), .rd_data(rd_data), .tx_ep_event(tx_ep_event),
                      .rx_ep_event(rx_ep_event), .tx_ep_cfg(tx_ep_cfg), .rx_ep_cfg(rx_ep_cfg),
                      .usb_irq(usb_irq), .ovr_irq(ovr_irq));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // event request; returns once the request line had a cycle to follow
  task automatic ev(input logic [3:0] t, input logic [3:0] r);
    @(posedge ref_clk);
    fire_tx <= t;
    fire_rx <= r;
    @(posedge ref_clk);
    fire_tx <= 4'h0;
    fire_rx <= 4'h0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    fails++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fire_tx = 4'h0;
    fire_rx = 4'h0;
    tx_ep_cfg = 4'hF;
    rx_ep_cfg = 4'hC;
    fails = 0;
    cmp_count = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, v);
        chk(v, rows[i].d);
      end
    end
    // receive flag raises request, clears on read
    ev(4'h0, 4'h4);
    chk({15'h0, usb_irq}, 16'h0001);
    rd(8'h04, v);
    chk(v, 16'h0004);
    rd(8'h04, v);
    chk(v, 16'h0000);
    chk({15'h0, usb_irq}, 16'h0000);
    // masked receive flag still sets
    wr(8'h08, 16'h0000);
    ev(4'h0, 4'h8);
    chk({15'h0, usb_irq}, 16'h0000);
    rd(8'h08, v);
    rd(8'h04, v);
    chk(v, 16'h0008);
    wr(8'h08, 16'hFFFF);
    // unconfigured and reserved receive bits
    ev(4'h0, 4'h3);
    chk({15'h0, usb_irq}, 16'h0000);
    rd(8'h04, v);
    chk(v, 16'h0000);
    // transmit flags with control endpoint bit
    ev(4'h9, 4'h0);
    chk({15'h0, usb_irq}, 16'h0001);
    rd(8'h02, v);
    chk(v, 16'h0009);
    wr(8'h06, 16'h0008);
    ev(4'h1, 4'h0);
    chk({15'h0, usb_irq}, 16'h0000);
    rd(8'h02, v);
    chk(v, 16'h0001);
    // second event on a pending flag raises the overrun request
    wr(8'h10, 16'h0003);
    ev(4'h0, 4'h4);
    chk({15'h0, ovr_irq}, 16'h0000);
    ev(4'h0, 4'h4);
    chk({15'h0, ovr_irq}, 16'h0001);
    rd(8'h0C, v);
    chk(v, 16'h0002);
    wr(8'h0E, 16'h0002);
    rd(8'h0C, v);
    chk(v, 16'h0000);
    chk({15'h0, ovr_irq}, 16'h0000);
    rd(8'h04, v);
    chk(v, 16'h0004);
    // event in the same cycle as the clearing read
    @(posedge ref_clk);
    rx_ep_cfg <= 4'hE;
    fire_rx <= 4'h2;
    @(posedge ref_clk);
    fire_rx <= 4'h0;
    addr <= 8'h04;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, 16'h0000);
    rd(8'h04, v);
    chk(v, 16'h0002);
    // reset in mid-run restores the masks
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h06, v);
    chk(v, 16'h000F);
    rd(8'h08, v);
    chk(v, 16'h000E);
    end_of_test();
  end
endmodule
